// File: hw/dcl_defines.svh
// register map, field positions, reset values and constants of the code ceiling bank
`ifndef DCL_DEFINES_SVH
`define DCL_DEFINES_SVH

// apb address width in bits; printed offsets are indexes, byte address is index * 4
`define DCL_AW          12
`define DCL_IDX_W       10
`define DCL_IDX_CEIL    10'h04F
`define DCL_IDX_MASK    10'h050

// reset values
`define DCL_CEIL_RST    16'h3F3F
`define DCL_MASK_RST    8'h00

// field positions in the ceiling register
`define DCL_B3_LSB      8
`define DCL_B3_MSB      13
`define DCL_B2_LSB      0
`define DCL_B2_MSB      5

// ceiling = field * 80h + 7Fh, so the low code bits are always all ones
`define DCL_CEIL_LOW    7'h7F
`define DCL_LIM_FULL    6'h3F

`endif

// File: hw/dcl_pkg.sv
// types shared by the code ceiling bank modules
package dcl_pkg;

  typedef logic [5:0]  dcl_lim_t;
  typedef logic [12:0] dcl_code_t;

  // one-hot register select, latched in the apb setup cycle
  typedef enum logic [2:0] {
    SEL_NONE = 3'b001,
    SEL_CEIL = 3'b010,
    SEL_MASK = 3'b100
  } dcl_sel_e;

endpackage : dcl_pkg

// File: hw/dcl_latch_if.sv
// interface between the register bank and one channel's clamping latch
`timescale 1ns/1ps
interface dcl_latch_if;
  import dcl_pkg::*;

  logic      latch;
  dcl_code_t code;
  dcl_lim_t  limit;
  dcl_code_t active;
  logic      clamped;

  modport bank  (output latch, output code, output limit, input active, input clamped);
  modport clamp (input latch, input code, input limit, output active, output clamped);
endinterface : dcl_latch_if

// File: hw/dcl_sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module dcl_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule : dcl_sync2

// File: hw/dcl_clamp.sv
// active register latch of one channel with its code ceiling
`timescale 1ns/1ps
`include "dcl_defines.svh"
module dcl_clamp
  import dcl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  arst_n,
  dcl_latch_if.clamp lif
);
  dcl_code_t ceiling;
  dcl_code_t active_ff;
  logic      clamped_ff;

  // field n gives n*80h+7Fh: the field is the six top code bits, the rest all ones
  assign ceiling = {lif.limit, `DCL_CEIL_LOW};

  // codes above the ceiling are cut to it; field 3Fh is full scale, nothing is cut
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_ff <= '0;
    end else if (lif.latch) begin
      active_ff <= (lif.code > ceiling) ? ceiling : lif.code;
    end
  end

  // one-cycle pulse telling that the last latch was cut
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clamped_ff <= 1'b0;
    end else begin
      clamped_ff <= lif.latch && (lif.code > ceiling);
    end
  end

  assign lif.active  = active_ff;
  assign lif.clamped = clamped_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_clamp_bound;
    lif.latch |=> active_ff <= {$past(lif.limit), 7'h7F};
  endproperty
  a_clamp_bound: assert property (p_clamp_bound) else $error("latched code above ceiling");

  property p_pass_below;
    lif.latch && (lif.code <= ceiling) |=> active_ff == $past(lif.code) && !clamped_ff;
  endproperty
  a_pass_below: assert property (p_pass_below) else $error("code under ceiling altered");

  property p_full_scale;
    lif.latch && (lif.limit == 6'h3F) |=> active_ff == $past(lif.code);
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full-scale field clamped");

  property p_zero_field;
    lif.latch && (lif.limit == 6'h00) && (lif.code > 13'h007F)
      |=> active_ff == 13'h007F && clamped_ff;
  endproperty
  a_zero_field: assert property (p_zero_field) else $error("field 0 ceiling not 007Fh");

  property p_low_bits;
    lif.latch && (lif.code > ceiling) |=> active_ff[6:0] == 7'h7F;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("clamped low bits not all ones");
endmodule : dcl_clamp

// File: hw/dcl_regs.sv
// code ceiling and drive pin 0 mask registers with apb slave and channel latches
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "dcl_defines.svh"
module dcl_regs
  import dcl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [`DCL_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ch_b2_latch,
  input  wire logic [12:0]       ch_b2_code,
  output logic      [12:0]       ch_b2_active,
  output logic                   ch_b2_clamped,
  input  wire logic              ch_b3_latch,
  input  wire logic [12:0]       ch_b3_code,
  output logic      [12:0]       ch_b3_active,
  output logic                   ch_b3_clamped,
  input  wire logic              drive_control_pin_0,
  output logic      [7:0]        pin0_gate,
  output logic      [7:0]        chan_pin_on
);
  localparam logic [`DCL_AW-1:0] ADDR_CEIL = {`DCL_IDX_CEIL, 2'b00};
  localparam logic [`DCL_AW-1:0] ADDR_MASK = {`DCL_IDX_MASK, 2'b00};
  localparam logic [15:0]        CEIL_RST  = `DCL_CEIL_RST;

  dcl_lim_t  ceil_b3_ff;
  dcl_lim_t  ceil_b2_ff;
  logic [7:0] mask_ff;
  dcl_sel_e  sel_ff;
  dcl_sel_e  nxt_sel;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] chan_on_ff;
  logic       pin_s;
  logic       setup;
  logic       access;
  logic       wr_ceil;
  logic       wr_mask;

  // ---------------- apb slave ----------------
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // address decode on the live bus; only whole aligned words are mapped
  always_comb begin
    if (paddr == ADDR_CEIL) begin
      nxt_sel = SEL_CEIL;
    end else if (paddr == ADDR_MASK) begin
      nxt_sel = SEL_MASK;
    end else begin
      nxt_sel = SEL_NONE;
    end
  end

  // read data is built from the register state in the setup cycle
  always_comb begin
    unique case (nxt_sel)
      SEL_CEIL: nxt_rdata = {16'h0000, 2'b00, ceil_b3_ff, 2'b00, ceil_b2_ff};
      SEL_MASK: nxt_rdata = {24'h000000, mask_ff};
      SEL_NONE: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // select and read data are captured at setup so prdata comes from a flip-flop;
  // a write can only land in an access cycle, so the captured value stays current
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_ff   <= SEL_NONE;
      rdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      sel_ff   <= nxt_sel;
      rdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
    end
  end

  // zero wait state: every access cycle completes
  assign pready  = access;
  assign pslverr = access && (sel_ff == SEL_NONE);
  assign prdata  = rdata_ff;

  assign wr_ceil = access && pwrite && (sel_ff == SEL_CEIL);
  assign wr_mask = access && pwrite && (sel_ff == SEL_MASK);

  // ---------------- registers ----------------
  // ceiling fields, each in its own byte lane; reserved bits are never stored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ceil_b3_ff <= CEIL_RST[`DCL_B3_MSB:`DCL_B3_LSB];
      ceil_b2_ff <= CEIL_RST[`DCL_B2_MSB:`DCL_B2_LSB];
    end else if (wr_ceil) begin
      if (pstrb[1]) begin
        ceil_b3_ff <= pwdata[`DCL_B3_MSB:`DCL_B3_LSB];
      end
      if (pstrb[0]) begin
        ceil_b2_ff <= pwdata[`DCL_B2_MSB:`DCL_B2_LSB];
      end
    end
  end

  // pin 0 channel mask; upper three bytes are reserved and read as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= `DCL_MASK_RST;
    end else if (wr_mask && pstrb[0]) begin
      mask_ff <= pwdata[7:0];
    end
  end

  // ---------------- drive pin gating ----------------
  // the pin is asynchronous to clk, so it is synchronised before any use
  dcl_sync2 #(
    .W (1)
  ) u_pin_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (drive_control_pin_0),
    .dout   (pin_s)
  );

  // a set mask bit hands the channel to the pin; a clear bit leaves it off the pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_on_ff <= 8'h00;
    end else begin
      chan_on_ff <= mask_ff & {8{pin_s}};
    end
  end

  assign pin0_gate   = mask_ff;
  assign chan_pin_on = chan_on_ff;

  // ---------------- channel latches ----------------
  dcl_latch_if lif_b2 ();
  dcl_latch_if lif_b3 ();

  assign lif_b2.latch = ch_b2_latch;
  assign lif_b2.code  = ch_b2_code;
  assign lif_b2.limit = ceil_b2_ff;
  assign lif_b3.latch = ch_b3_latch;
  assign lif_b3.code  = ch_b3_code;
  assign lif_b3.limit = ceil_b3_ff;

  dcl_clamp u_clamp_b2 (
    .clk    (clk),
    .arst_n (arst_n),
    .lif    (lif_b2)
  );

  dcl_clamp u_clamp_b3 (
    .clk    (clk),
    .arst_n (arst_n),
    .lif    (lif_b3)
  );

  assign ch_b2_active  = lif_b2.active;
  assign ch_b2_clamped = lif_b2.clamped;
  assign ch_b3_active  = lif_b3.active;
  assign ch_b3_clamped = lif_b3.clamped;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_setup_ceil_rd;
    psel && !penable && !pwrite && (paddr == 12'h13C);
  endsequence

  sequence s_setup_mask_rd;
    psel && !penable && !pwrite && (paddr == 12'h140);
  endsequence

  sequence s_acc_wr(logic [11:0] a);
    psel && !penable && pwrite && (paddr == a) ##1 psel && penable;
  endsequence

  property p_ceil_read;
    s_setup_ceil_rd |=> prdata == {18'h0, $past(ceil_b3_ff), 2'b00, $past(ceil_b2_ff)};
  endproperty
  a_ceil_read: assert property (p_ceil_read) else $error("ceiling readback wrong");

  property p_ceil_rsvd;
    s_setup_ceil_rd |=> prdata[31:14] == 18'h0 && prdata[7:6] == 2'b00;
  endproperty
  a_ceil_rsvd: assert property (p_ceil_rsvd) else $error("ceiling reserved bits set");

  property p_b3_write;
    s_acc_wr(12'h13C) ##0 pstrb[1] |=> ceil_b3_ff == $past(pwdata[13:8]);
  endproperty
  a_b3_write: assert property (p_b3_write) else $error("channel 3 field not written");

  property p_b2_write;
    s_acc_wr(12'h13C) ##0 pstrb[0] |=> ceil_b2_ff == $past(pwdata[5:0]);
  endproperty
  a_b2_write: assert property (p_b2_write) else $error("channel 2 field not written");

  property p_mask_write;
    s_acc_wr(12'h140) ##0 pstrb[0] |=> mask_ff == $past(pwdata[7:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_mask_read;
    s_setup_mask_rd |=> prdata == {24'h0, $past(mask_ff)};
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");

  property p_pin_high;
    drive_control_pin_0 [*4] |-> chan_pin_on == $past(mask_ff);
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("masked channels miss pin");

  property p_pin_low;
    !drive_control_pin_0 [*4] |-> chan_pin_on == 8'h00;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("channel on with pin low");

  property p_unmapped;
    psel && !penable && (paddr != 12'h13C) && (paddr != 12'h140) ##1 psel && penable
      |-> pslverr && pready && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule : dcl_regs

// File: verification/dcl_regs_tb.sv
// self-checking bench of the code ceiling and drive pin 0 mask registers
`timescale 1ns/1ps
`include "dcl_defines.svh"
module dcl_regs_tb;
  localparam logic [11:0] CEIL_ADDR = 12'h13C;
  localparam logic [11:0] MASK_ADDR = 12'h140;
  localparam logic [11:0] BAD_ADDR  = 12'h144;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [3:0]  strb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ch_b2_latch = 1'b0;
  logic [12:0] ch_b2_code = 13'h0;
  logic [12:0] ch_b2_active;
  logic        ch_b2_clamped;
  logic        ch_b3_latch = 1'b0;
  logic [12:0] ch_b3_code = 13'h0;
  logic [12:0] ch_b3_active;
  logic        ch_b3_clamped;
  logic        drive_control_pin_0 = 1'b0;
  logic [7:0]  pin0_gate;
  logic [7:0]  chan_pin_on;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  dcl_regs uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_b2_latch(ch_b2_latch), .ch_b2_code(ch_b2_code),
    .ch_b2_active(ch_b2_active), .ch_b2_clamped(ch_b2_clamped), .ch_b3_latch(ch_b3_latch),
    .ch_b3_code(ch_b3_code), .ch_b3_active(ch_b3_active), .ch_b3_clamped(ch_b3_clamped),
    .drive_control_pin_0(drive_control_pin_0), .pin0_gate(pin0_gate),
    .chan_pin_on(chan_pin_on));

  // 20 MHz clock
  always #25 clk = ~clk;

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_code(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // entered just after a rising edge; leaves one idle cycle so the next call never collides
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk_bit(pready, 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic reg_write(input logic [11:0] a, input logic [31:0] d, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
    chk_bit(e, experr);
  endtask : reg_write

  task automatic reg_check(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk_word(r, exp);
    chk_bit(e, experr);
  endtask : reg_check

  // one latch pulse on channel b3 (sel high) or b2, then active value and clamp flag
  task automatic latch_chk(input logic sel, input logic [12:0] code, input logic [12:0] exp,
                           input logic expc);
    ch_b2_latch <= ~sel;
    ch_b3_latch <= sel;
    ch_b2_code  <= code;
    ch_b3_code  <= code;
    @(posedge clk);
    ch_b2_latch <= 1'b0;
    ch_b3_latch <= 1'b0;
    #1;
    chk_code(sel ? ch_b3_active : ch_b2_active, exp);
    chk_bit(sel ? ch_b3_clamped : ch_b2_clamped, expc);
    @(posedge clk);
  endtask : latch_chk

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic t_reset_values();
    reg_check(CEIL_ADDR, 32'h0000_3F3F, 1'b0);
    reg_check(MASK_ADDR, 32'h0000_0000, 1'b0);
    chk_word({24'h0, pin0_gate}, 32'h0000_0000);
  endtask : t_reset_values

  task automatic t_ceiling_fields();
    reg_write(CEIL_ADDR, 32'hFFFF_FFFF, 1'b0);
    reg_check(CEIL_ADDR, 32'h0000_3F3F, 1'b0);
    // low byte lane only: the channel 3 field must keep its value
    strb = 4'h1;
    reg_write(CEIL_ADDR, 32'h0000_0000, 1'b0);
    strb = 4'hF;
    reg_check(CEIL_ADDR, 32'h0000_3F00, 1'b0);
    reg_write(CEIL_ADDR, 32'h0000_1F00, 1'b0);
    reg_check(CEIL_ADDR, 32'h0000_1F00, 1'b0);
  endtask : t_ceiling_fields

  // b3 field 1Fh, b2 field 00h at entry; then mid-range fields and full scale
  task automatic t_clamp();
    latch_chk(1'b0, 13'h1FFF, 13'h007F, 1'b1);
    latch_chk(1'b0, 13'h0080, 13'h007F, 1'b1);
    latch_chk(1'b0, 13'h0050, 13'h0050, 1'b0);
    latch_chk(1'b1, 13'h1FFF, 13'h0FFF, 1'b1);
    latch_chk(1'b1, 13'h0FFF, 13'h0FFF, 1'b0);
    reg_write(CEIL_ADDR, 32'h0000_0A2B, 1'b0);
    latch_chk(1'b1, 13'h0580, 13'h057F, 1'b1);
    latch_chk(1'b0, 13'h15FF, 13'h15FF, 1'b0);
    latch_chk(1'b0, 13'h1600, 13'h15FF, 1'b1);
    reg_write(CEIL_ADDR, 32'h0000_3F3F, 1'b0);
    latch_chk(1'b1, 13'h1FFF, 13'h1FFF, 1'b0);
    latch_chk(1'b0, 13'h1FFF, 13'h1FFF, 1'b0);
  endtask : t_clamp

  // the pin reaches the channel outputs three edges after it changes
  task automatic t_mask();
    reg_write(MASK_ADDR, 32'hFFFF_01A5, 1'b0);
    reg_check(MASK_ADDR, 32'h0000_00A5, 1'b0);
    chk_word({24'h0, pin0_gate}, 32'h0000_00A5);
    drive_control_pin_0 <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_word({24'h0, chan_pin_on}, 32'h0000_00A5);
    @(posedge clk);
    drive_control_pin_0 <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_word({24'h0, chan_pin_on}, 32'h0000_0000);
    @(posedge clk);
  endtask : t_mask

  // unmapped word: refused, reads zero, and leaves the mask untouched
  task automatic t_unmapped();
    reg_write(BAD_ADDR, 32'h0000_FFFF, 1'b1);
    reg_check(BAD_ADDR, 32'h0000_0000, 1'b1);
    reg_check(MASK_ADDR, 32'h0000_00A5, 1'b0);
  endtask : t_unmapped

  initial begin
    do_reset();
    t_reset_values();
    t_ceiling_fields();
    t_clamp();
    t_mask();
    t_unmapped();
    do_reset();
    t_reset_values();
    end_of_test();
  end
endmodule : dcl_regs_tb
